// File: dv/srpp_core_model.sv
// Processor core model issuing loads, stores and fetches
`timescale 1ns/1ps
module srpp_core_model
  import srpp_pkg::*;
(
  input wire logic hclk,
  output srpp_req_t req
);
  initial req = '0;
  // Idle slots invert the released fields so stale values never look valid
  task automatic send(input srpp_req_t r);
    srpp_req_t n;
    @(posedge hclk);
    n = r;
    if (!r.valid) begin
      n = srpp_req_t'(~req);
      n.valid = 1'b0;
    end
    req <= n;
  endtask : send
endmodule : srpp_core_model

// File: dv/testbench.sv
// Self-checking bench for the segment range and page protection checker
`timescale 1ns/1ps
module testbench
  import srpp_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, dbg_illegal, irq, en, pv;
  logic [31:0] haddr, hwdata, hrdata, r, fa;
  logic [1:0] htrans;
  logic [2:0] hsize, st, msk;
  srpp_req_t req, q;
  srpp_mem_t mem, em;
  srpp_trap_t trap, et;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h31AFB29C;
  logic [31:0] bnd [48];
  logic [31:0] dmode [4];
  logic [31:0] cmode [4];
  always #2 hclk = ~hclk;
  srpp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req(req), .mem(mem), .trap(trap),
    .dbg_illegal(dbg_illegal), .irq(irq));
  srpp_core_model core (.hclk(hclk), .req(req));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, a};
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task automatic predict(input srpp_req_t x);
    logic priv, pg, bp, hit, ok;
    int b;
    priv = x.user0 & (x.virt_mode ? x.addr[31] : x.addr[31:28] >= SRPP_SEG_U0_LO);
    pg = x.virt_mode & !x.addr[31];
    bp = x.kind == SRPP_READ ? !x.pread : x.kind == SRPP_WRITE ? !x.pwrite : !x.pexec;
    hit = !en;
    for (int k = 0; k < 6; k++) begin
      b = (x.set_sel * 6 + k) * 2;
      ok = k < 4 ? x.kind != SRPP_FETCH && dmode[x.set_sel][3 * k + (x.kind == SRPP_WRITE)]
                 : x.kind == SRPP_FETCH && cmode[x.set_sel][3 * (k - 4) + 2];
      if (ok && x.addr >= bnd[b] && x.addr < bnd[b + 1]) hit = 1'b1;
    end
    et = '{x.valid & !priv & !pg & !hit, x.valid & !priv & pg & bp, x.valid & priv};
    em = '{x.valid & !(|et), x.kind, pg ? {x.pframe, x.addr[11:0]} : x.addr};
    st |= {et.trap_priv, et.trap_page, et.trap_range};
    if (|et) fa = x.addr;
  endtask : predict
  task automatic step(input srpp_req_t x);
    core.send(x);
    #1;
    if (pv) begin
      chk({mem.valid, trap, dbg_illegal, irq}, {em.valid, et, |et, |(st & msk)});
      if (em.valid) chk({mem.kind, mem.paddr}, {em.kind, em.paddr});
    end
    pv = 1'b1;
    predict(x);
  endtask : step
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata, en, pv, fa} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({mem.valid, trap, dbg_illegal, irq, hreadyout, hresp}, 64'h2);
    for (int i = 0; i < 48; i++) begin
      bnd[i] = rnd();
      ahb(1'b1, SRPP_OFF_BND + 12'(4 * i), bnd[i]);
    end
    for (int s = 0; s < 4; s++) begin
      dmode[s] = rnd();
      cmode[s] = rnd();
      ahb(1'b1, SRPP_OFF_DMODE + 12'(4 * s), dmode[s]);
      ahb(1'b1, SRPP_OFF_CMODE + 12'(4 * s), cmode[s]);
    end
    ahb(1'b0, 12'h800, 32'h0);
    chk(r, 64'h0);
    ahb(1'b0, SRPP_OFF_BND + 12'h014, 32'h0);
    chk(r, {32'h0, bnd[5]});
    ahb(1'b0, SRPP_OFF_DMODE + 12'h008, 32'h0);
    chk(r, {52'h0, dmode[2][11:0]});
    ahb(1'b0, SRPP_OFF_CMODE + 12'h004, 32'h0);
    chk(r, {58'h0, cmode[1][5:0]});
    for (int p = 0; p < 2; p++) begin
      en = p[0];
      msk = 3'(rnd());
      ahb(1'b1, SRPP_OFF_CTRL, {31'h0, en});
      ahb(1'b1, SRPP_OFF_MASK, {29'h0, msk});
      ahb(1'b0, SRPP_OFF_CTRL, 32'h0);
      chk(r, {63'h0, en});
      ahb(1'b0, SRPP_OFF_MASK, 32'h0);
      chk(r, {61'h0, msk});
      ahb(1'b0, SRPP_OFF_STAT, 32'h0);
      {st, pv} = '0;
      repeat (400) begin
        void'(rnd());
        {q.pframe, q.user0, q.virt_mode, q.set_sel, q.pread, q.pwrite, q.pexec} = seed[26:0];
        q.valid = seed[30] | seed[29];
        q.kind = srpp_kind_t'(rnd() % 3);
        q.addr = rnd();
        if (seed[4]) q.addr = bnd[seed[10:5] % 48];
        step(q);
      end
      step('0);
      ahb(1'b0, SRPP_OFF_STAT, 32'h0);
      chk(r, {61'h0, st});
      ahb(1'b0, SRPP_OFF_STAT, 32'h0);
      chk(r, 64'h0);
      ahb(1'b0, SRPP_OFF_ADDR, 32'h0);
      chk(r, {32'h0, fa});
      @(posedge hclk);
      #1;
      chk(irq, 64'h0);
    end
    stop_test();
  end
endmodule : testbench

// File: verilog/srpp_pkg.sv
// Package for the segment range and page protection checker
package srpp_pkg;
  localparam int SRPP_SETS = 4;
  localparam int SRPP_DRANGES = 4;
  localparam int SRPP_CRANGES = 2;
  localparam int SRPP_SEG_MSB = 31;
  localparam int SRPP_SEG_LSB = 28;
  localparam logic [3:0] SRPP_SEG_U0_LO = 4'hE;
  localparam int SRPP_PAGE_LSB = 12;
  // Register offsets
  localparam logic [11:0] SRPP_OFF_CTRL = 12'h000;
  localparam logic [11:0] SRPP_OFF_STAT = 12'h004;
  localparam logic [11:0] SRPP_OFF_MASK = 12'h008;
  localparam logic [11:0] SRPP_OFF_ADDR = 12'h00C;
  localparam logic [11:0] SRPP_OFF_BND = 12'h100;
  localparam logic [11:0] SRPP_OFF_DMODE = 12'h200;
  localparam logic [11:0] SRPP_OFF_CMODE = 12'h210;
  // Status bit positions
  localparam int SRPP_ST_RANGE = 0;
  localparam int SRPP_ST_PAGE = 1;
  localparam int SRPP_ST_PRIV = 2;
  localparam logic [2:0] SRPP_STAT_RST = 3'h0;

  typedef enum logic [1:0] {SRPP_READ, SRPP_WRITE, SRPP_FETCH} srpp_kind_t;

  typedef struct packed {
    logic valid;
    srpp_kind_t kind;
    logic [31:0] addr;
    logic user0;
    logic virt_mode;
    logic [1:0] set_sel;
    logic [19:0] pframe;
    logic pread;
    logic pwrite;
    logic pexec;
  } srpp_req_t;

  typedef struct packed {
    logic valid;
    srpp_kind_t kind;
    logic [31:0] paddr;
  } srpp_mem_t;

  typedef struct packed {
    logic trap_range;
    logic trap_page;
    logic trap_priv;
  } srpp_trap_t;
endpackage : srpp_pkg

// File: verilog/srpp_top.sv
// Segment range and page protection checker with AHB-Lite registers
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module srpp_top
  import srpp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire srpp_req_t req,
  output srpp_mem_t mem,
  output srpp_trap_t trap,
  output logic dbg_illegal,
  output logic irq
);
  localparam int NB = SRPP_SETS * (SRPP_DRANGES + SRPP_CRANGES) * 2;

  typedef struct packed {
    logic [NB-1:0][31:0] bnd;
    logic [SRPP_SETS-1:0][3*SRPP_DRANGES-1:0] dmode;
    logic [SRPP_SETS-1:0][3*SRPP_CRANGES-1:0] cmode;
    logic enable;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] fault_addr;
    logic ap_wr;
    logic ap_rd;
    logic [11:0] ap_off;
    logic [31:0] rdata;
    srpp_mem_t mem;
    srpp_trap_t trap;
    logic dbg;
    logic irq;
  } srpp_st_t;

  srpp_st_t s_q;
  srpp_st_t s_d;

  logic [3:0] seg;
  logic upper;
  logic paged;
  logic [31:0] paddr;
  logic range_ok;
  logic page_ok;
  logic priv_bad;
  logic [2:0] ev;
  logic [1:0] ps;
  logic [2:0] m;
  int bi;

  initial begin
    if (SRPP_SETS != 4 || SRPP_DRANGES != 4 || SRPP_CRANGES != 2) begin
      $error("srpp_top: unsupported protection geometry");
    end
  end

  always_comb begin
    seg = req.addr[SRPP_SEG_MSB:SRPP_SEG_LSB];
    upper = seg[3];
    paged = !upper && req.virt_mode;
    paddr = paged ? {req.pframe, req.addr[SRPP_PAGE_LSB-1:0]} : req.addr;
    ps = req.set_sel;
    range_ok = 1'b0;
    // Range checks on the selected set, data or code part by access kind
    if (req.kind == SRPP_FETCH) begin
      for (int r = 0; r < SRPP_CRANGES; r++) begin
        bi = ((int'(ps) * (SRPP_DRANGES + SRPP_CRANGES)) + SRPP_DRANGES + r) * 2;
        m = s_q.cmode[ps][3*r +: 3];
        if (req.addr >= s_q.bnd[bi] && req.addr < s_q.bnd[bi+1] && m[2]) begin
          range_ok = 1'b1;
        end
      end
    end else begin
      for (int r = 0; r < SRPP_DRANGES; r++) begin
        bi = ((int'(ps) * (SRPP_DRANGES + SRPP_CRANGES)) + r) * 2;
        m = s_q.dmode[ps][3*r +: 3];
        if (req.addr >= s_q.bnd[bi] && req.addr < s_q.bnd[bi+1] &&
            ((req.kind == SRPP_READ && m[0]) || (req.kind == SRPP_WRITE && m[1]))) begin
          range_ok = 1'b1;
        end
      end
    end
    if (!s_q.enable) begin
      range_ok = 1'b1;
    end
    page_ok = (req.kind == SRPP_FETCH && req.pexec) ||
              (req.kind == SRPP_WRITE && req.pwrite) ||
              (req.kind == SRPP_READ && req.pread);
    priv_bad = req.user0 && (req.virt_mode ? upper : (seg >= SRPP_SEG_U0_LO));
    ev[SRPP_ST_PRIV] = req.valid && priv_bad;
    ev[SRPP_ST_PAGE] = req.valid && !priv_bad && paged && !page_ok;
    ev[SRPP_ST_RANGE] = req.valid && !priv_bad && !paged && !range_ok;

    s_d = s_q;
    s_d.mem.valid = req.valid && (ev == 3'h0);
    s_d.mem.kind = req.kind;
    s_d.mem.paddr = paddr;
    s_d.trap.trap_range = ev[SRPP_ST_RANGE];
    s_d.trap.trap_page = ev[SRPP_ST_PAGE];
    s_d.trap.trap_priv = ev[SRPP_ST_PRIV];
    s_d.dbg = |ev;
    if (|ev) begin
      s_d.fault_addr = req.addr;
    end

    // AHB-Lite data phase
    if (s_q.ap_wr) begin
      if (s_q.ap_off == SRPP_OFF_CTRL) begin
        s_d.enable = hwdata[0];
      end else if (s_q.ap_off == SRPP_OFF_MASK) begin
        s_d.mask = hwdata[2:0];
      end else if (s_q.ap_off >= SRPP_OFF_BND && s_q.ap_off < SRPP_OFF_BND + 12'(NB * 4)) begin
        s_d.bnd[(s_q.ap_off - SRPP_OFF_BND) >> 2] = hwdata;
      end else if (s_q.ap_off >= SRPP_OFF_DMODE && s_q.ap_off < SRPP_OFF_DMODE + 12'h010) begin
        s_d.dmode[s_q.ap_off[3:2]] = hwdata[3*SRPP_DRANGES-1:0];
      end else if (s_q.ap_off >= SRPP_OFF_CMODE && s_q.ap_off < SRPP_OFF_CMODE + 12'h010) begin
        s_d.cmode[s_q.ap_off[3:2]] = hwdata[3*SRPP_CRANGES-1:0];
      end
    end
    // Read clears only the bits it reported; events that arrive meanwhile stay and win
    if (s_q.ap_rd && s_q.ap_off == SRPP_OFF_STAT) begin
      s_d.stat = s_q.stat & ~s_q.rdata[2:0];
    end
    s_d.stat = s_d.stat | ev;

    s_d.ap_wr = hsel && hready && htrans[1] && hwrite;
    s_d.ap_rd = hsel && hready && htrans[1] && !hwrite;
    s_d.ap_off = haddr[11:0];
    // Read data stands through the data phase and until the next read
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_d.rdata = 32'h0;
      if (haddr[11:0] == SRPP_OFF_CTRL) begin
        s_d.rdata = {31'h0, s_q.enable};
      end else if (haddr[11:0] == SRPP_OFF_STAT) begin
        s_d.rdata = {29'h0, s_q.stat};
      end else if (haddr[11:0] == SRPP_OFF_MASK) begin
        s_d.rdata = {29'h0, s_q.mask};
      end else if (haddr[11:0] == SRPP_OFF_ADDR) begin
        s_d.rdata = s_q.fault_addr;
      end else if (haddr[11:0] >= SRPP_OFF_BND && haddr[11:0] < SRPP_OFF_BND + 12'(NB * 4)) begin
        s_d.rdata = s_q.bnd[(haddr[11:0] - SRPP_OFF_BND) >> 2];
      end else if (haddr[11:0] >= SRPP_OFF_DMODE && haddr[11:0] < SRPP_OFF_DMODE + 12'h010) begin
        s_d.rdata = {20'h0, s_q.dmode[haddr[3:2]]};
      end else if (haddr[11:0] >= SRPP_OFF_CMODE && haddr[11:0] < SRPP_OFF_CMODE + 12'h010) begin
        s_d.rdata = {26'h0, s_q.cmode[haddr[3:2]]};
      end
    end
    s_d.irq = |(s_d.stat & s_q.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem = s_q.mem;
  assign trap = s_q.trap;
  assign dbg_illegal = s_q.dbg;
  assign irq = s_q.irq;

  // Privilege screening: user0 is barred from the top of the map in either mode
  priv_upper_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.user0 && req.virt_mode && req.addr[31] |=> trap.trap_priv && !mem.valid)
    else $error("user0 upper access not trapped");
  priv_seg_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.user0 && !req.virt_mode && req.addr[31:29] == 3'h7 |=> trap.trap_priv)
    else $error("user0 top segment not trapped");
  priv_phys_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.user0 && !req.virt_mode && req.addr[31:28] == 4'hD |=> !trap.trap_priv)
    else $error("segment 13 wrongly trapped");
  priv_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trap.trap_priv |-> !trap.trap_page && !trap.trap_range)
    else $error("privilege trap not exclusive");
  // Address paths
  upper_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.addr[31] |=> mem.paddr == $past(req.addr))
    else $error("upper half address altered");
  phys_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && !req.virt_mode |=> mem.paddr == $past(req.addr))
    else $error("physical mode address altered");
  page_xlat_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.virt_mode && !req.addr[31] |=> mem.paddr[31:12] == $past(req.pframe))
    else $error("page frame not applied");
  // Page permissions apply only on the translated path
  page_exec_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && !req.user0 && req.virt_mode && !req.addr[31] && req.kind == SRPP_FETCH
    && !req.pexec |=> trap.trap_page)
    else $error("fetch without execute permit");
  page_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && req.virt_mode && !req.addr[31] |=> !trap.trap_range)
    else $error("range check on translated access");
  // With range checking off, a direct access by a privileged task always passes
  range_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req.valid && !req.user0 && !req.virt_mode && !s_q.enable |=> mem.valid)
    else $error("disabled range check blocked access");
  suppress_a: assert property (@(posedge hclk) disable iff (!hresetn)
    |trap |-> !mem.valid && dbg_illegal)
    else $error("faulting access not suppressed");
  dbg_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    dbg_illegal |-> |trap)
    else $error("debug pulse without trap");
  stat_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    trap.trap_range |-> stat_bit_range())
    else $error("range event not recorded");
  function automatic logic stat_bit_range();
    return s_q.stat[SRPP_ST_RANGE];
  endfunction : stat_bit_range
  cov_range_c: cover property (@(posedge hclk) disable iff (!hresetn) trap.trap_range);
  cov_page_c: cover property (@(posedge hclk) disable iff (!hresetn) trap.trap_page);
  cov_priv_c: cover property (@(posedge hclk) disable iff (!hresetn) trap.trap_priv);
  cov_irq_c: cover property (@(posedge hclk) disable iff (!hresetn) irq);
  cov_fetch_c: cover property (@(posedge hclk) disable iff (!hresetn)
    mem.valid && mem.kind == SRPP_FETCH);
endmodule : srpp_top
